// ==== design/dfo_pkg.sv ====
// Shared constants and carrier types for the drive fault and frequency detect outputs
package dfo_pkg;

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  A_USER_GRP    = 8'h00;
  localparam logic [7:0]  A_BAND        = 8'h04;
  localparam logic [7:0]  A_FDET_LVL    = 8'h08;
  localparam logic [7:0]  A_FDET_REV    = 8'h0c;
  localparam logic [7:0]  A_FDET2_LVL   = 8'h10;
  localparam logic [7:0]  A_HYST        = 8'h14;
  localparam logic [7:0]  A_STATUS      = 8'h18;
  localparam logic [7:0]  A_IRQ_STAT    = 8'h1c;
  localparam logic [7:0]  A_IRQ_CLR     = 8'h20;
  localparam logic [7:0]  A_IRQ_EN      = 8'h24;
  localparam logic [7:0]  A_TERM_BASE   = 8'h40;

  // ----------------------------------------
  // Settings: frequencies in 0.1 Hz steps
  // ----------------------------------------
  localparam logic [15:0] BAND_RST      = 16'h000a;
  localparam logic [15:0] BAND_MAX      = 16'h0064;
  localparam logic [15:0] FDET_RST      = 16'h003c;
  localparam logic [15:0] FDET2_RST     = 16'h012c;
  localparam logic [15:0] FREQ_MAX      = 16'h0fa0;
  localparam logic [15:0] REV_SAME      = 16'h270f;
  localparam logic [15:0] HYST_RST      = 16'h0000;
  localparam logic [15:0] HYST_MAX      = 16'h0032;
  localparam logic [16:0] PCT_DIV       = 17'h00064;

  // ----------------------------------------
  // Terminal function codes
  // ----------------------------------------
  localparam logic [9:0]  FC_AT_SPEED   = 10'h001;
  localparam logic [9:0]  FC_FDET       = 10'h004;
  localparam logic [9:0]  FC_FDET2      = 10'h005;
  localparam logic [9:0]  FC_SHUTOFF    = 10'h05b;
  localparam logic [9:0]  FC_HOLD       = 10'h05e;
  localparam logic [9:0]  FC_FAULT      = 10'h063;
  localparam logic [9:0]  FC_INV_OFS    = 10'h064;
  localparam logic [9:0]  FC_INV_END    = 10'h0c8;
  localparam logic [9:0]  FC_NONE       = 10'h3e7;

  // ----------------------------------------
  // Event bits and timing
  // ----------------------------------------
  localparam int          N_EV          = 5;
  localparam int          EV_TRIP       = 0;
  localparam int          EV_SHUTOFF    = 1;
  localparam int          EV_AT_SPEED   = 2;
  localparam int          EV_FDET       = 3;
  localparam int          EV_FDET2      = 4;
  localparam int          N_INT_FAULT   = 11;
  localparam int          CLK_HZ        = 10_000_000;
  localparam int          CTRL_NS       = 1000;
  localparam int          CTRL_CYC      = (CTRL_NS * (CLK_HZ / 1_000_000)) / 1000;

  typedef struct packed {
    logic [15:0] band;
    logic [15:0] fdet_lvl;
    logic [15:0] fdet_rev;
    logic [15:0] fdet2_lvl;
    logic [15:0] hyst;
  } dfo_cfg_t;

  typedef struct packed {
    logic fault;
    logic hold;
    logic shutoff;
    logic at_speed;
    logic fdet;
    logic fdet2;
  } dfo_flags_t;

endpackage

// ==== design/dfo_status_out.sv ====
// Fault indication, contactor shutoff and frequency detection outputs with terminal routing
//
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/1ps

// Functional notes
// - Internal or wiring fault raises contactor shutoff
// - Shutoff routed by code 91 or 191
// - Exactly eleven listed faults raise shutoff
// - Any trip raises fault and held fault
// - Held fault stays through reset period
// - Held fault routed by code 94 or 194
// - Relay contact one carries fault by default
// - At-speed within percentage band of set frequency
// - Frequency detect at or above level
// - Reverse level used unless it reads 9999
// - Second detect at or above second level
// - Hysteresis applied to all three detections
// - Compared frequency depends on control method
// - Detect settings writable only when group zero
// - Codes below 100 conduct, 100-199 invert
// - Fault output drops when fault reset
// - Power removal drops held fault at once
module dfo_status_out
  import dfo_pkg::*;
#(
  parameter int N_TERM   = 7,
  parameter int CTRL_DIV = CTRL_CYC
)(
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  input  wire logic [ADDR_W-1:0]      reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [31:0]            reg_rdata,
  input  wire logic [15:0]            out_freq,
  input  wire logic [15:0]            out_freq_pre_slip,
  input  wire logic [15:0]            set_freq,
  input  wire logic                   dir_reverse,
  input  wire logic                   flux_vector_mode,
  input  wire logic [N_INT_FAULT-1:0] int_fault,
  input  wire logic                   other_trip,
  input  wire logic                   drive_reset_active,
  input  wire logic                   power_loss,
  output logic                        fault_out,
  output logic                        fault_out_hold,
  output logic                        input_contactor_shutoff,
  output logic                        at_speed,
  output logic                        freq_detect,
  output logic                        freq_detect_second,
  output logic                        relay_contact_one,
  output logic      [N_TERM-1:0]      term_conduct,
  output logic                        irq
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  dfo_cfg_t          cfg_q;
  dfo_flags_t        flg;
  logic [7:0]        user_grp_q;
  logic [9:0]        term_fc_q [N_TERM];
  logic [N_EV-1:0]   irq_sts_q;
  logic [N_EV-1:0]   irq_en_q;
  logic [N_EV-1:0]   ev;
  logic [31:0]       rdata_q;
  logic              irq_q, fault_q, hold_q, rst_seen_q, shut_q;
  logic              su_q, fu_q, fu2_q;
  logic [15:0]       div_q;
  logic              tick, trip, wr_ok;
  logic [15:0]       wd16;
  logic [N_TERM-1:0] term_q;

  assign wd16  = reg_wdata[15:0];
  assign tick  = (div_q == 16'(CTRL_DIV - 1));
  assign wr_ok = reg_wr && (user_grp_q == 8'h00);

  // ----------------------------------------
  // Control update divider
  // ----------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || tick)
      div_q <= 16'h0000;
    else
      div_q <= div_q + 16'h0001;
  end

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      user_grp_q      <= 8'h00;
      cfg_q.band      <= BAND_RST;
      cfg_q.fdet_lvl  <= FDET_RST;
      cfg_q.fdet_rev  <= REV_SAME;
      cfg_q.fdet2_lvl <= FDET2_RST;
      cfg_q.hyst      <= HYST_RST;
      irq_en_q        <= '0;
    end
    else
    begin
      if (reg_wr && reg_addr == A_USER_GRP)
        user_grp_q <= reg_wdata[7:0];
      if (reg_wr && reg_addr == A_IRQ_EN)
        irq_en_q <= reg_wdata[N_EV-1:0];
      // Out-of-range values are ignored
      if (wr_ok && reg_addr == A_BAND && wd16 <= BAND_MAX)
        cfg_q.band <= wd16;
      if (wr_ok && reg_addr == A_FDET_LVL && wd16 <= FREQ_MAX)
        cfg_q.fdet_lvl <= wd16;
      if (wr_ok && reg_addr == A_FDET_REV && (wd16 <= FREQ_MAX || wd16 == REV_SAME))
        cfg_q.fdet_rev <= wd16;
      if (wr_ok && reg_addr == A_FDET2_LVL && wd16 <= FREQ_MAX)
        cfg_q.fdet2_lvl <= wd16;
      if (wr_ok && reg_addr == A_HYST && wd16 <= HYST_MAX)
        cfg_q.hyst <= wd16;
    end
  end

  // Terminal function codes; terminal 0 is relay contact one
  for (genvar i = 0; i < N_TERM; i++)
  begin : g_fc
    always_ff @(posedge clk_sys)
    begin
      if (!rst_n)
        term_fc_q[i] <= (i == 0) ? FC_FAULT : FC_NONE;
      else if (reg_wr && reg_addr == A_TERM_BASE + 8'(4 * i))
        term_fc_q[i] <= reg_wdata[9:0];
    end
  end

  // ----------------------------------------
  // Fault outputs
  // ----------------------------------------
  // eleven listed fault sources plus other_trip
  assign trip = (|int_fault) || other_trip;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      fault_q    <= 1'b0;
      hold_q     <= 1'b0;
      rst_seen_q <= 1'b0;
      shut_q     <= 1'b0;
    end
    else
    begin
      fault_q <= trip || (fault_q && !drive_reset_active && !power_loss);
      shut_q  <= (|int_fault) || (shut_q && !drive_reset_active && !power_loss);
      rst_seen_q <= hold_q && !trip && drive_reset_active;
      hold_q <= trip || (hold_q && !power_loss && !(rst_seen_q && !drive_reset_active));
    end
  end

  // ----------------------------------------
  // Frequency detection
  // ----------------------------------------
  logic [15:0] fcmp, lvl1, lo1, lo2;
  logic [16:0] diff, band_w;
  logic [31:0] band_p;

  assign fcmp   = flux_vector_mode ? out_freq_pre_slip : out_freq;
  assign lvl1   = (dir_reverse && cfg_q.fdet_rev != REV_SAME) ? cfg_q.fdet_rev
                                                              : cfg_q.fdet_lvl;
  assign diff   = (fcmp >= set_freq) ? 17'(fcmp - set_freq) : 17'(set_freq - fcmp);
  assign band_p = (32'(set_freq) * 32'(cfg_q.band)) / 32'(PCT_DIV);
  assign band_w = band_p[16:0];
  assign lo1    = (lvl1 > cfg_q.hyst) ? lvl1 - cfg_q.hyst : 16'h0000;
  assign lo2    = (cfg_q.fdet2_lvl > cfg_q.hyst) ? cfg_q.fdet2_lvl - cfg_q.hyst : 16'h0000;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      su_q  <= 1'b0;
      fu_q  <= 1'b0;
      fu2_q <= 1'b0;
    end
    else if (tick)
    begin
      su_q  <= su_q ? (diff <= band_w + 17'(cfg_q.hyst)) : (diff <= band_w);
      fu_q  <= fu_q ? (fcmp >= lo1) : (fcmp >= lvl1);
      fu2_q <= fu2_q ? (fcmp >= lo2) : (fcmp >= cfg_q.fdet2_lvl);
    end
  end

  // ----------------------------------------
  // Terminal routing
  // ----------------------------------------
  assign flg = '{fault: fault_q, hold: hold_q, shutoff: shut_q,
                 at_speed: su_q, fdet: fu_q, fdet2: fu2_q};

  function automatic logic fc_active(input logic [9:0] c, input dfo_flags_t f);
    case (c)
      FC_AT_SPEED: return f.at_speed;
      FC_FDET:     return f.fdet;
      FC_FDET2:    return f.fdet2;
      FC_SHUTOFF:  return f.shutoff;
      FC_HOLD:     return f.hold;
      FC_FAULT:    return f.fault;
      default:     return 1'b0;
    endcase
  endfunction

  for (genvar i = 0; i < N_TERM; i++)
  begin : g_term
    always_ff @(posedge clk_sys)
    begin
      if (!rst_n || term_fc_q[i] >= FC_INV_END)
        term_q[i] <= 1'b0;
      else if (term_fc_q[i] < FC_INV_OFS)
        term_q[i] <= fc_active(term_fc_q[i], flg);
      else
        term_q[i] <= !fc_active(term_fc_q[i] - FC_INV_OFS, flg);
    end
  end

  // ----------------------------------------
  // Interrupts and read data
  // ----------------------------------------
  assign ev[EV_TRIP]     = trip && !fault_q;
  assign ev[EV_SHUTOFF]  = (|int_fault) && !shut_q;
  // Rises are seen from the next value, since each output is its own flop
  assign ev[EV_AT_SPEED] = tick && !su_q && (diff <= band_w);
  assign ev[EV_FDET]     = tick && !fu_q && (fcmp >= lvl1);
  assign ev[EV_FDET2]    = tick && !fu2_q && (fcmp >= cfg_q.fdet2_lvl);

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      irq_sts_q <= '0;
      irq_q     <= 1'b0;
    end
    else
    begin
      // A new event wins over a same-cycle clear
      if (reg_wr && reg_addr == A_IRQ_CLR)
        irq_sts_q <= (irq_sts_q & ~reg_wdata[N_EV-1:0]) | ev;
      else
        irq_sts_q <= irq_sts_q | ev;
      irq_q <= |(irq_sts_q & irq_en_q);
    end
  end

  always_ff @(posedge clk_sys)
  begin
    rdata_q <= 32'h0000_0000;
    if (rst_n && reg_rd)
    begin
      case (reg_addr)
        A_USER_GRP:  rdata_q <= {24'h000000, user_grp_q};
        A_BAND:      rdata_q <= {16'h0000, cfg_q.band};
        A_FDET_LVL:  rdata_q <= {16'h0000, cfg_q.fdet_lvl};
        A_FDET_REV:  rdata_q <= {16'h0000, cfg_q.fdet_rev};
        A_FDET2_LVL: rdata_q <= {16'h0000, cfg_q.fdet2_lvl};
        A_HYST:      rdata_q <= {16'h0000, cfg_q.hyst};
        A_STATUS:    rdata_q <= {26'h0000000, flg};
        A_IRQ_STAT:  rdata_q <= {27'h0000000, irq_sts_q};
        A_IRQ_EN:    rdata_q <= {27'h0000000, irq_en_q};
        default:
          for (int i = 0; i < N_TERM; i++)
            if (reg_addr == A_TERM_BASE + 8'(4 * i))
              rdata_q <= {22'h000000, term_fc_q[i]};
      endcase
    end
  end

  assign reg_rdata               = rdata_q;
  assign fault_out               = fault_q;
  assign fault_out_hold          = hold_q;
  assign input_contactor_shutoff = shut_q;
  assign at_speed                = su_q;
  assign freq_detect             = fu_q;
  assign freq_detect_second      = fu2_q;
  assign term_conduct            = term_q;
  assign relay_contact_one       = term_q[0];
  assign irq                     = irq_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_SHUTOFF_SET: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (|int_fault) |=> input_contactor_shutoff && fault_out)
    else $error("shutoff not raised by internal fault");
  AST_TRIP_BOTH: assert property (@(posedge clk_sys) disable iff (!rst_n)
    trip |=> fault_out && fault_out_hold)
    else $error("trip did not raise both fault outputs");
  AST_HOLD_RESET: assert property (@(posedge clk_sys) disable iff (!rst_n)
    fault_out_hold && drive_reset_active && !power_loss |=> fault_out_hold)
    else $error("held fault dropped during reset");
  AST_FAULT_CLR: assert property (@(posedge clk_sys) disable iff (!rst_n)
    drive_reset_active && !trip |=> !fault_out)
    else $error("fault output not cleared by reset");
  AST_PWR_DROP: assert property (@(posedge clk_sys) disable iff (!rst_n)
    power_loss && !trip |=> !fault_out_hold)
    else $error("held fault kept on power loss");
  AST_FDET_ON: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tick && fcmp >= lvl1 |=> freq_detect)
    else $error("frequency detect missed");
  AST_FDET2_ON: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tick && fcmp >= cfg_q.fdet2_lvl |=> freq_detect_second)
    else $error("second detect missed");
  AST_FDET_OFF: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tick && fcmp < lo1 |=> !freq_detect)
    else $error("frequency detect not released");
  AST_LOCK: assert property (@(posedge clk_sys) disable iff (!rst_n)
    reg_wr && user_grp_q != 8'h00 && reg_addr == A_FDET_LVL |=> $stable(cfg_q.fdet_lvl))
    else $error("locked setting changed");
  AST_INV_TERM: assert property (@(posedge clk_sys) disable iff (!rst_n)
    term_fc_q[0] == FC_FAULT + FC_INV_OFS && $stable(term_fc_q[0]) ##1
    $stable(fault_out) |-> relay_contact_one == !fault_out)
    else $error("inverted terminal wrong");

endmodule

// ==== tb/dfo_contactor_model.sv ====
// Supply contactor whose coil hangs on the shutoff output terminal
`timescale 1ns/1ps
module dfo_contactor_model (
  input  wire logic       clk_sys,
  input  wire logic [6:0] term_conduct,
  output logic            contactor_closed
);
  logic pick_q;

  // Coil pick-up and drop-out take two clock cycles
  always_ff @(posedge clk_sys)
  begin
    pick_q           <= term_conduct[2];
    contactor_closed <= pick_q;
  end
endmodule

// ==== tb/dfo_status_out_bench.sv ====
// Self-checking bench for the fault and frequency detection outputs
`timescale 1ns/1ps
module dfo_status_out_bench;
  import dfo_pkg::*;
  typedef struct {string nm; int s; logic [31:0] e; logic [31:0] m;} dfo_note_t;
  logic                   clk_sys, rst_n, reg_wr, reg_rd, dir_reverse, flux_vector_mode;
  logic                   other_trip, drive_reset_active, power_loss, contactor_closed;
  logic [7:0]             reg_addr;
  logic [31:0]            reg_wdata, reg_rdata, lfsr;
  logic [15:0]            out_freq, out_freq_pre_slip, set_freq;
  logic [N_INT_FAULT-1:0] int_fault;
  logic                   fault_out, fault_out_hold, input_contactor_shutoff, at_speed;
  logic                   freq_detect, freq_detect_second, relay_contact_one, irq;
  logic [6:0]             term_conduct;
  int                     failures, compares;
  dfo_note_t              q[$];
  wire  [8:0]             flg = {contactor_closed, irq, relay_contact_one,
                                 freq_detect_second, freq_detect, at_speed,
                                 input_contactor_shutoff, fault_out_hold, fault_out};

  dfo_status_out #(.CTRL_DIV(2)) dut (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .out_freq, .out_freq_pre_slip, .set_freq, .dir_reverse,
    .flux_vector_mode, .int_fault, .other_trip, .drive_reset_active, .power_loss,
    .fault_out, .fault_out_hold, .input_contactor_shutoff, .at_speed, .freq_detect,
    .freq_detect_second, .relay_contact_one, .term_conduct, .irq);

  dfo_contactor_model relay (.clk_sys, .term_conduct, .contactor_closed);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] nxt(logic [31:0] l);
    return {l[30:0], l[31] ^ l[21] ^ l[1] ^ l[0]};
  endfunction

  // Selector 0 read data, 1..9 single flags, 10 terminal vector
  function automatic logic [31:0] obs(int s);
    if (s == 0)
      return reg_rdata;
    if (s == 10)
      return 32'(term_conduct);
    return 32'(flg[s-1]);
  endfunction

  task automatic cmp(string nm, logic [31:0] e, logic [31:0] v);
    compares++;
    if (v !== e)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, v);
    end
  endtask

  task automatic note(string nm, int s, logic [31:0] e, logic [31:0] m = 32'hffffffff);
    q.push_back('{nm, s, e, m});
  endtask

  task automatic step(int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic sync();
    @(negedge clk_sys);
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    step(1);
    reg_wr    <= 1'h1;
    reg_addr  <= a;
    reg_wdata <= d;
    step(1);
    reg_wr    <= 1'h0;
  endtask

  task automatic rd(string nm, logic [7:0] a, logic [31:0] e, logic [31:0] m = 32'hffffffff);
    step(1);
    reg_rd   <= 1'h1;
    reg_addr <= a;
    step(1);
    reg_rd   <= 1'h0;
    sync();
    note(nm, 0, e, m);
  endtask

  task automatic complete_run();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------
  // Clock, monitor, watchdog
  // ----------------------------------------
  initial
  begin
    clk_sys = 1'h0;
    forever #50 clk_sys = ~clk_sys;
  end

  initial
  begin
    dfo_note_t n;
    forever
    begin
      @(negedge clk_sys);
      #1;
      while (q.size() > 0)
      begin
        n = q.pop_front();
        cmp(n.nm, n.e & n.m, obs(n.s) & n.m);
      end
    end
  end

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    complete_run();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    int         sf, of, ps, fc, lv, b, d, lvl, rev, h;
    logic       sp, fd, f2, dr, fx;
    logic [2:0] op, rs;
    logic [9:0] codes [1:6];
    codes = '{10'h05e, 10'h0bf, 10'h05b, 10'h001, 10'h068, 10'h005};
    {rst_n, reg_wr, reg_rd, dir_reverse, flux_vector_mode} = 5'h0;
    {other_trip, drive_reset_active, power_loss} = 3'h0;
    {reg_addr, reg_wdata, out_freq, out_freq_pre_slip, set_freq} = '0;
    int_fault = '0;
    lfsr = 32'h00014e4c;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'h1;
    rd("band", A_BAND, 32'(BAND_RST));
    rd("level", A_FDET_LVL, 32'(FDET_RST));
    rd("rev level", A_FDET_REV, 32'(REV_SAME));
    rd("level2", A_FDET2_LVL, 32'(FDET2_RST));
    rd("hyst", A_HYST, 32'(HYST_RST));
    rd("term0 code", A_TERM_BASE, 32'(FC_FAULT));
    rd("unmapped", 8'hfc, 32'h0);
    $display("test defaults done");
    for (int i = 1; i < 7; i++)
      wr(A_TERM_BASE + 8'(4 * i), 32'(codes[i]));
    wr(A_FDET_LVL, 32'h64);
    wr(A_FDET_REV, 32'hc8);
    wr(A_HYST, 32'h14);
    wr(A_USER_GRP, 32'h1);
    wr(A_FDET_LVL, 32'h5);
    wr(A_USER_GRP, 32'h0);
    wr(A_HYST, 32'h33);
    rd("level locked", A_FDET_LVL, 32'h64);
    rd("hyst range", A_HYST, 32'h14);
    lvl = 100;
    rev = 200;
    h   = 20;
    wr(A_IRQ_EN, 32'h0);
    wr(A_IRQ_CLR, 32'h1f);
    $display("test settings done");
    step(1);
    other_trip <= 1'h1;
    step(3);
    sync();
    note("fault", 1, 32'h1);
    note("hold", 2, 32'h1);
    note("shutoff", 3, 32'h0);
    note("relay one", 7, 32'h1);
    note("term hold", 10, 32'h2, 32'h2);
    note("irq masked", 8, 32'h0);
    wr(A_IRQ_EN, 32'h1);
    step(2);
    sync();
    note("irq", 8, 32'h1);
    rd("irq stat", A_IRQ_STAT, 32'h1, 32'h1);
    step(1);
    other_trip <= 1'h0;
    wr(A_IRQ_CLR, 32'h1);
    step(2);
    sync();
    note("irq clr", 8, 32'h0);
    step(1);
    drive_reset_active <= 1'h1;
    step(3);
    sync();
    note("fault reset", 1, 32'h0);
    note("hold reset", 2, 32'h1);
    step(1);
    drive_reset_active <= 1'h0;
    step(2);
    sync();
    note("hold after", 2, 32'h0);
    $display("test trip done");
    for (int i = 0; i < N_INT_FAULT; i++)
    begin
      step(1);
      int_fault <= N_INT_FAULT'(1 << i);
      step(4);
      sync();
      note("shutoff", 3, 32'h1);
      note("trip", 1, 32'h1);
      note("term shutoff", 10, 32'h8, 32'hc);
      note("contactor", 9, 32'h0);
      step(1);
      int_fault  <= '0;
      power_loss <= 1'h1;
      step(1);
      sync();
      note("hold power", 2, 32'h0);
      step(1);
      power_loss <= 1'h0;
      step(2);
      sync();
      note("term idle", 10, 32'h4, 32'hc);
      note("contactor closed", 9, 32'h1);
    end
    $display("test shutoff done");
    {sp, fd, f2} = 3'b100;
    rs = 3'h0;
    for (int k = 0; k < 200; k++)
    begin
      if (k == 100)
      begin
        wr(A_FDET_REV, 32'(REV_SAME));
        rev = 9999;
        // Old inputs meet the shared level for one tick before they change
        step(2);
        rs[1] = rs[1] | (!fd && fc >= lvl);
        fd    = fd ? fc >= lvl - h : fc >= lvl;
      end
      lfsr = nxt(lfsr);
      sf = 64 + lfsr[8:0];
      of = lfsr[12] ? sf + lfsr[5:0] - 32 : lfsr[24:16];
      ps = of + lfsr[3:0];
      dr = lfsr[13];
      fx = lfsr[14];
      fc = fx ? ps : of;
      lv = (dr && rev != 9999) ? rev : lvl;
      op = {f2, fd, sp};
      fd = fd ? fc >= lv - h : fc >= lv;
      f2 = f2 ? fc >= 300 - h : fc >= 300;
      b  = sf * 10 / 100;
      d  = fc > sf ? fc - sf : sf - fc;
      sp = sp ? d <= b + h : d <= b;
      rs = rs | ({f2, fd, sp} & ~op);
      step(1);
      set_freq          <= 16'(sf);
      out_freq          <= 16'(of);
      out_freq_pre_slip <= 16'(ps);
      dir_reverse       <= dr;
      flux_vector_mode  <= fx;
      step(5);
      sync();
      note("at speed", 4, 32'(sp));
      note("detect", 5, 32'(fd));
      note("detect2", 6, 32'(f2));
      note("terms", 10, {25'h0, f2, ~fd, sp, 4'h0}, 32'h70);
    end
    rd("irq events", A_IRQ_STAT, 32'({rs, 2'h3}));
    $display("test frequency done");
    wr(A_TERM_BASE, 32'(FC_FAULT + FC_INV_OFS));
    step(2);
    sync();
    note("relay inverted", 7, 32'h1);
    step(1);
    other_trip <= 1'h1;
    step(3);
    sync();
    note("relay inverted trip", 7, 32'h0);
    $display("test inverted relay done");
    step(2);
    complete_run();
  end
endmodule
